/* rtl/dcr_cfg.svh */
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
// ***********************************************
// Register byte addresses
// ***********************************************
`define DCR_ADDR_W 16
`define DCR_OFF_ACQ_CTRL 16'h8100
`define DCR_OFF_REF_DIV 16'h8104
`define DCR_OFF_FB_DIV 16'h8108
`define DCR_OFF_SAMP_DIV 16'h810C
`define DCR_OFF_OUT_DIV 16'h8110
`define DCR_OFF_OUT_DEL 16'h8114
`define DCR_OFF_CLK_CTRL 16'h8118
`define DCR_OFF_APPLY 16'h811C
`define DCR_OFF_STATUS 16'h8120
`define DCR_OFF_CHAIN_PHASE 16'h8124
// ***********************************************
// Field positions
// ***********************************************
`define DCR_ACQ_MODE_LSB 0
`define DCR_ACQ_RUN_BIT 2
`define DCR_CLK_OUT_EN_BIT 0
`define DCR_CLK_FOLLOW_BIT 1
`define DCR_ST_RUN_BIT 0
`define DCR_ST_INHIBIT_BIT 1
`define DCR_ST_EXT_BIT 2
`define DCR_ST_FOLLOW_BIT 3
`define DCR_ST_APPLIED_BIT 4
// ***********************************************
// Reset values
// ***********************************************
`define DCR_RST_FB_DIV 8'h64
`define DCR_RST_REF_DIV 8'h05
`define DCR_RST_SAMP_DIV 8'h04
`define DCR_RST_OUT_DIV 8'h01
`define DCR_RST_OUT_DEL 8'h00
`define DCR_RST_PHASE 8'h00
// ***********************************************
// Timing
// ***********************************************
`define DCR_CLK_MHZ 100
`define DCR_OSC_MHZ 50
`define DCR_OSC_HALF (`DCR_CLK_MHZ / (2 * `DCR_OSC_MHZ))
`endif

/* rtl/dcr_pkg.sv */
package dcr_pkg;
  typedef enum logic [1:0] {
    DCR_MODE_SW,
    DCR_MODE_INPUT,
    DCR_MODE_RSV2,
    DCR_MODE_RSV3
  } dcr_mode_t;
  typedef enum logic [1:0] {
    DCR_IDLE,
    DCR_ARMED,
    DCR_RUN,
    DCR_STOPPING
  } dcr_run_t;
endpackage : dcr_pkg

/* rtl/dcr_clock_run.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dcr_cfg.svh"

module dcr_clock_run #(
  parameter int DIV_W = 8,
  parameter int DLY_MAX = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic clock_source_switch_i,
  input wire logic ext_ref_i,
  input wire logic chain_clk_i,
  input wire logic front_run_i,
  input wire logic busy_i,
  input wire logic chain_busy_i,
  output logic board_oscillator_clock_o,
  output logic [3:0] converter_sample_clock_o,
  output logic trigger_logic_clock_o,
  output logic fwd_clk_o,
  output logic chain_busy_o,
  output logic acq_enable_o,
  output logic time_zero_o,
  output logic [30:0] time_stamp_o
);

  // ***********************************************
  // Elaboration checks
  // ***********************************************
  generate
    if (DIV_W < 8 || DIV_W > 16) begin : g_bad_div
      $error("DIV_W must lie between 8 and 16");
    end
    if (DLY_MAX < 2 || DLY_MAX > 256) begin : g_bad_dly
      $error("DLY_MAX must lie between 2 and 256");
    end
  endgenerate

  localparam int DLY_W = $clog2(DLY_MAX);

  // Divider step: reports wrap when the count reaches div-1; zero acts as one
  function automatic logic div_wrap(input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] div);
    logic [DIV_W-1:0] lim;
    lim = (div == '0) ? '0 : DIV_W'(div - 1'b1);
    div_wrap = (cnt >= lim);
  endfunction : div_wrap

  // ***********************************************
  // Board oscillator
  // ***********************************************
  logic osc_q;
  logic [3:0] osc_cnt_q;

  // The whole register slave lives on this clock; osc_q is its 50 MHz image
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_q <= 4'h0;
      osc_q <= 1'b0;
    end else if (osc_cnt_q == 4'(`DCR_OSC_HALF - 1)) begin
      osc_cnt_q <= 4'h0;
      osc_q <= ~osc_q;
    end else begin
      osc_cnt_q <= 4'(osc_cnt_q + 1'b1);
    end
  end

  // ***********************************************
  // Register slave
  // ***********************************************
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] mode_q;
  logic run_bit_q;
  logic [DIV_W-1:0] st_ref_q, st_fb_q, st_samp_q, st_out_q, st_del_q;
  logic st_out_en_q, st_follow_q;
  logic [DIV_W-1:0] ref_div_q, fb_div_q, samp_div_q, out_div_q, out_del_q;
  logic out_en_q, follow_q, applied_q;
  logic [DLY_W-1:0] phase_q;
  logic running_q, inhibit_q;
  logic wr_en, rd_en;

  assign wr_en = write_i && !wait_q;
  assign rd_en = read_i && wait_q;
  assign waitrequest_o = wait_q;
  assign readdata_o = rdata_q;

  // One wait cycle per access; the edge where waitrequest is low completes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((read_i || write_i) && wait_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 2'h0;
      run_bit_q <= 1'b0;
      st_ref_q <= DIV_W'(`DCR_RST_REF_DIV);
      st_fb_q <= DIV_W'(`DCR_RST_FB_DIV);
      st_samp_q <= DIV_W'(`DCR_RST_SAMP_DIV);
      st_out_q <= DIV_W'(`DCR_RST_OUT_DIV);
      st_del_q <= DIV_W'(`DCR_RST_OUT_DEL);
      st_out_en_q <= 1'b0;
      st_follow_q <= 1'b0;
      phase_q <= DLY_W'(`DCR_RST_PHASE);
    end else if (wr_en && byteenable_i[0]) begin
      case (address_i)
        `DCR_OFF_ACQ_CTRL: begin
          mode_q <= writedata_i[`DCR_ACQ_MODE_LSB +: 2];
          run_bit_q <= writedata_i[`DCR_ACQ_RUN_BIT];
        end
        `DCR_OFF_REF_DIV: st_ref_q <= writedata_i[DIV_W-1:0];
        `DCR_OFF_FB_DIV: st_fb_q <= writedata_i[DIV_W-1:0];
        `DCR_OFF_SAMP_DIV: st_samp_q <= writedata_i[DIV_W-1:0];
        `DCR_OFF_OUT_DIV: st_out_q <= writedata_i[DIV_W-1:0];
        `DCR_OFF_OUT_DEL: st_del_q <= writedata_i[DIV_W-1:0];
        `DCR_OFF_CLK_CTRL: begin
          st_out_en_q <= writedata_i[`DCR_CLK_OUT_EN_BIT];
          st_follow_q <= writedata_i[`DCR_CLK_FOLLOW_BIT];
        end
        `DCR_OFF_CHAIN_PHASE: phase_q <= writedata_i[DLY_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Staged settings reach the dividers together, so no mixed set is ever live
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_div_q <= DIV_W'(`DCR_RST_REF_DIV);
      fb_div_q <= DIV_W'(`DCR_RST_FB_DIV);
      samp_div_q <= DIV_W'(`DCR_RST_SAMP_DIV);
      out_div_q <= DIV_W'(`DCR_RST_OUT_DIV);
      out_del_q <= DIV_W'(`DCR_RST_OUT_DEL);
      out_en_q <= 1'b0;
      follow_q <= 1'b0;
      applied_q <= 1'b0;
    end else if (wr_en && byteenable_i[0] && address_i == `DCR_OFF_APPLY) begin
      ref_div_q <= st_ref_q;
      fb_div_q <= st_fb_q;
      samp_div_q <= st_samp_q;
      out_div_q <= st_out_q;
      out_del_q <= st_del_q;
      out_en_q <= st_out_en_q;
      follow_q <= st_follow_q;
      applied_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (address_i)
        `DCR_OFF_ACQ_CTRL: rdata_q <= {29'h0, run_bit_q, mode_q};
        `DCR_OFF_REF_DIV: rdata_q <= 32'(st_ref_q);
        `DCR_OFF_FB_DIV: rdata_q <= 32'(st_fb_q);
        `DCR_OFF_SAMP_DIV: rdata_q <= 32'(st_samp_q);
        `DCR_OFF_OUT_DIV: rdata_q <= 32'(st_out_q);
        `DCR_OFF_OUT_DEL: rdata_q <= 32'(st_del_q);
        `DCR_OFF_CLK_CTRL: rdata_q <= {30'h0, st_follow_q, st_out_en_q};
        `DCR_OFF_STATUS: rdata_q <= {27'h0, applied_q, follow_q, clock_source_switch_i, inhibit_q, running_q};
        `DCR_OFF_CHAIN_PHASE: rdata_q <= 32'(phase_q);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************
  // Reference selection and chain phase
  // ***********************************************
  logic ext_s1_q, ext_s2_q, chn_s1_q, chn_s2_q;
  logic [DLY_MAX-1:0] chn_dly_q;
  logic ref_lvl, ref_prev_q, ref_rise, sel_ext;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      chn_s1_q <= 1'b0;
      chn_s2_q <= 1'b0;
      chn_dly_q <= '0;
      ref_prev_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_ref_i;
      ext_s2_q <= ext_s1_q;
      chn_s1_q <= chain_clk_i;
      chn_s2_q <= chn_s1_q;
      chn_dly_q <= {chn_dly_q[DLY_MAX-2:0], chn_s2_q};
      ref_prev_q <= ref_lvl;
    end
  end

  // Follow mode takes the chain clock; else the board switch picks the source
  assign sel_ext = follow_q || clock_source_switch_i;
  assign ref_lvl = follow_q ? chn_dly_q[phase_q] : ext_s2_q;
  assign ref_rise = ref_lvl && !ref_prev_q;

  // ***********************************************
  // Sample, trigger and forwarded clocks
  // ***********************************************
  logic [DIV_W-1:0] samp_cnt_q, out_cnt_q, del_cnt_q;
  logic samp_q, trig_q, fwd_q, samp_step, samp_edge, trig_edge, fwd_go_q;

  // The internal source runs off clk_i; an external one steps per reference edge
  assign samp_step = sel_ext ? ref_rise : 1'b1;
  assign samp_edge = samp_step && div_wrap(samp_cnt_q, samp_div_q) && !samp_q;
  assign trig_edge = samp_edge && !trig_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_cnt_q <= '0;
      samp_q <= 1'b0;
    end else if (samp_step) begin
      if (div_wrap(samp_cnt_q, samp_div_q)) begin
        samp_cnt_q <= '0;
        samp_q <= ~samp_q;
      end else begin
        samp_cnt_q <= DIV_W'(samp_cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
    end else if (samp_edge) begin
      trig_q <= ~trig_q;
    end
  end

  // Delay counts sample edges after enabling, then the output divider runs
  always_ff @(posedge clk_i) begin
    if (rst_i || !out_en_q) begin
      del_cnt_q <= '0;
      out_cnt_q <= '0;
      fwd_go_q <= 1'b0;
      fwd_q <= 1'b0;
    end else if (samp_edge) begin
      if (!fwd_go_q) begin
        if (del_cnt_q >= out_del_q) begin
          fwd_go_q <= 1'b1;
        end else begin
          del_cnt_q <= DIV_W'(del_cnt_q + 1'b1);
        end
      end else if (div_wrap(out_cnt_q, out_div_q)) begin
        out_cnt_q <= '0;
        fwd_q <= ~fwd_q;
      end else begin
        out_cnt_q <= DIV_W'(out_cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      board_oscillator_clock_o <= 1'b0;
      converter_sample_clock_o <= 4'h0;
      trigger_logic_clock_o <= 1'b0;
      fwd_clk_o <= 1'b0;
    end else begin
      board_oscillator_clock_o <= osc_q;
      converter_sample_clock_o <= {4{samp_q}};
      trigger_logic_clock_o <= trig_q;
      fwd_clk_o <= fwd_q;
    end
  end

  // ***********************************************
  // Run control
  // ***********************************************
  logic fr_s1_q, fr_s2_q, fr_prev_q, bit_prev_q, run_req_q;
  dcr_pkg::dcr_run_t state_q;
  logic mode_ok, in_mode;

  assign mode_ok = (mode_q == dcr_pkg::DCR_MODE_SW) || (mode_q == dcr_pkg::DCR_MODE_INPUT);
  assign in_mode = (mode_q == dcr_pkg::DCR_MODE_INPUT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fr_s1_q <= 1'b0;
      fr_s2_q <= 1'b0;
      fr_prev_q <= 1'b0;
      bit_prev_q <= 1'b0;
    end else begin
      fr_s1_q <= front_run_i;
      fr_s2_q <= fr_s1_q;
      fr_prev_q <= fr_s2_q;
      bit_prev_q <= run_bit_q;
    end
  end

  // Edge driven so either source can start or stop in input mode; the latest edge wins
  always_ff @(posedge clk_i) begin
    if (rst_i || !mode_ok) begin
      run_req_q <= 1'b0;
    end else if (run_bit_q && !bit_prev_q) begin
      run_req_q <= 1'b1;
    end else if (!run_bit_q && bit_prev_q) begin
      run_req_q <= 1'b0;
    end else if (in_mode && fr_s2_q && !fr_prev_q) begin
      run_req_q <= 1'b1;
    end else if (in_mode && !fr_s2_q && fr_prev_q) begin
      run_req_q <= 1'b0;
    end
  end

  // Start and stop land on a trigger clock edge so chained boards agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= dcr_pkg::DCR_IDLE;
    end else begin
      case (state_q)
        dcr_pkg::DCR_IDLE: if (run_req_q) state_q <= dcr_pkg::DCR_ARMED;
        dcr_pkg::DCR_ARMED: begin
          if (!run_req_q) begin
            state_q <= dcr_pkg::DCR_IDLE;
          end else if (trig_edge) begin
            state_q <= dcr_pkg::DCR_RUN;
          end
        end
        dcr_pkg::DCR_RUN: if (!run_req_q) state_q <= dcr_pkg::DCR_STOPPING;
        dcr_pkg::DCR_STOPPING: begin
          if (trig_edge) begin
            state_q <= dcr_pkg::DCR_IDLE;
          end
        end
        default: state_q <= dcr_pkg::DCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_q <= 1'b0;
      inhibit_q <= 1'b0;
      chain_busy_o <= 1'b0;
      acq_enable_o <= 1'b0;
    end else begin
      running_q <= (state_q == dcr_pkg::DCR_RUN) || (state_q == dcr_pkg::DCR_STOPPING);
      inhibit_q <= busy_i || chain_busy_i;
      chain_busy_o <= busy_i || chain_busy_i;
      acq_enable_o <= running_q && !(busy_i || chain_busy_i);
    end
  end

  // Time stamp clears at start and counts trigger clock edges while running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_stamp_o <= 31'h0000_0000;
      time_zero_o <= 1'b0;
    end else begin
      time_zero_o <= (state_q == dcr_pkg::DCR_ARMED) && run_req_q && trig_edge;
      if ((state_q == dcr_pkg::DCR_ARMED) && trig_edge) begin
        time_stamp_o <= 31'h0000_0000;
      end else if (running_q && trig_edge) begin
        time_stamp_o <= 31'(time_stamp_o + 1'b1);
      end
    end
  end

endmodule : dcr_clock_run
`default_nettype wire

/* bench/dcr_clock_run_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module dcr_clock_run_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic busy_i,
  input wire logic chain_busy_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic board_oscillator_clock_o,
  input wire logic [3:0] converter_sample_clock_o,
  input wire logic fwd_clk_o,
  input wire logic chain_busy_o,
  input wire logic acq_enable_o,
  input wire logic time_zero_o
);
  // ***********************************************
  // Helpers and checks
  // ***********************************************
  // Age counter skips the edges where $past still sees reset values
  logic [1:0] age_q;
  logic wr_seen_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) wr_seen_q <= 1'b0;
    else if (write_i && !waitrequest_o) wr_seen_q <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("no answer one cycle after request");
  chk_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property (!waitrequest_o |-> $past(read_i || write_i))
    else $error("answer without request");
  chk_osc_toggle: assert property (age_q == 2'h3 |-> board_oscillator_clock_o != $past(board_oscillator_clock_o))
    else $error("oscillator clock not at half system rate");
  chk_conv_copies: assert property (converter_sample_clock_o == 4'h0 || converter_sample_clock_o == 4'hF)
    else $error("converter clock copies differ");
  chk_busy_or: assert property (age_q[1] |-> chain_busy_o == $past(busy_i || chain_busy_i))
    else $error("chain busy out is not the busy or");
  chk_busy_inhibit: assert property ((busy_i || chain_busy_i) |=> !acq_enable_o)
    else $error("acquisition enabled while busy");
  chk_fwd_reset_off: assert property (!wr_seen_q |-> !fwd_clk_o)
    else $error("forwarded clock active before any setup");
  chk_unmapped_zero: assert property (read_i && waitrequest_o && address_i == 16'h8200 |=> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_tz_single: assert property (time_zero_o |=> !time_zero_o)
    else $error("time zero pulse too long");
  cover property (write_i && !waitrequest_o);
  cover property ($rose(acq_enable_o));
  cover property (chain_busy_o && chain_busy_i);
  cover property ($rose(fwd_clk_o));
endmodule : dcr_clock_run_chk
bind dcr_clock_run dcr_clock_run_chk chk (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .busy_i(busy_i), .chain_busy_i(chain_busy_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .board_oscillator_clock_o(board_oscillator_clock_o),
  .converter_sample_clock_o(converter_sample_clock_o), .fwd_clk_o(fwd_clk_o), .chain_busy_o(chain_busy_o),
  .acq_enable_o(acq_enable_o), .time_zero_o(time_zero_o));
`default_nettype wire

/* bench/dcr_chain_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module dcr_chain_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic busy_req_i,
  output logic chain_clk_o,
  output logic chain_busy_o
);
  // ***********************************************
  // Upstream board
  // ***********************************************
  logic [1:0] cnt_q;
  // Master clock runs free; rate is clk/2 or clk/4, both submultiples of the loop rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      chain_clk_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (!slow_i || cnt_q[0]) chain_clk_o <= !chain_clk_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) chain_busy_o <= 1'b0;
    else chain_busy_o <= busy_req_i;
  end
endmodule : dcr_chain_peer
`default_nettype wire

/* bench/tb_digitizer_clocking_and_run_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_digitizer_clocking_and_run_control;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr_en = 1'b0, sw = 1'b0, front = 1'b0, busy = 1'b0;
  logic slow = 1'b0, busy_req = 1'b0, wait_o, osc, trig, fwd, cb_o, acq, tz, pclk, pbusy;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] be = 4'hF, conv;
  logic [30:0] ts;
  int err_count = 0, compares = 0, tz_n = 0;
  always #5 clk = !clk;
  always @(posedge clk) if (tz === 1'b1) tz_n++;
  dcr_chain_peer peer (.clk_i(clk), .rst_i(rst), .slow_i(slow), .busy_req_i(busy_req), .chain_clk_o(pclk),
    .chain_busy_o(pbusy));
  dcr_clock_run uut (.clk_i(clk), .rst_i(rst), .address_i(addr), .read_i(rd), .write_i(wr_en),
    .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wait_o),
    .clock_source_switch_i(sw), .ext_ref_i(pclk), .chain_clk_i(pclk), .front_run_i(front), .busy_i(busy),
    .chain_busy_i(pbusy), .board_oscillator_clock_o(osc), .converter_sample_clock_o(conv),
    .trigger_logic_clock_o(trig), .fwd_clk_o(fwd), .chain_busy_o(cb_o), .acq_enable_o(acq),
    .time_zero_o(tz), .time_stamp_o(ts));
  // ***********************************************
  // Tasks
  // ***********************************************
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Request held until waitrequest is sampled low, then released
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr_en <= w;
    @(posedge clk);
    while (wait_o !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    q = rdata;
    check("waitrequest", wait_o, 1'b0);
    rd <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : bus
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check("readdata", q, e);
  endtask : rdc
  task wacq(input logic e);
    int n;
    n = 0;
    while (acq !== e && n < 300) begin
      n++;
      @(posedge clk);
    end
    check("acq_enable", acq, e);
  endtask : wacq
  // Counts rising edges of one converter clock copy over a window
  task rises(input int cyc, output int k);
    logic p;
    k = 0;
    p = conv[0];
    repeat (cyc) begin
      @(posedge clk);
      if (conv[0] === 1'b1 && p === 1'b0) k++;
      p = conv[0];
    end
  endtask : rises
  task conclude;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  // ***********************************************
  // Tests
  // ***********************************************
  initial begin
    int n, cs, tcs;
    logic p, pc, pt;
    logic [30:0] ts0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(16'h8104, 32'h5);
    rdc(16'h8108, 32'h64);
    rdc(16'h810C, 32'h4);
    rdc(16'h8110, 32'h1);
    rdc(16'h8200, 32'h0);
    rdc(16'h8120, 32'h0);
    check("fwd_clk", fwd, 1'b0);
    be <= 4'h0;
    wr(16'h8114, 32'h7);
    be <= 4'hF;
    rdc(16'h8114, 32'h0);
    n = 0;
    p = osc;
    repeat (20) begin
      @(posedge clk);
      if (osc !== p) n++;
      p = osc;
    end
    check("osc_toggles", n, 20);
    cs = 0;
    tcs = 0;
    pc = conv[0];
    pt = trig;
    repeat (320) begin
      @(posedge clk);
      if (conv[0] === 1'b1 && pc === 1'b0) cs++;
      if (trig === 1'b1 && pt === 1'b0) tcs++;
      pc = conv[0];
      pt = trig;
    end
    check("trig_ratio", cs >= 2 * tcs - 1 && cs <= 2 * tcs + 1 && cs > 0, 1'b1);
    $display("test clocks done");
    wr(16'h8100, 32'h4);
    wacq(1'b1);
    check("time_zero", tz_n, 1);
    check("ts_start", ts, 32'h0);
    rdc(16'h8120, 32'h1);
    ts0 = ts;
    tcs = 0;
    pt = trig;
    repeat (64) begin
      @(posedge clk);
      if (trig === 1'b1 && pt === 1'b0) tcs++;
      pt = trig;
    end
    check("time_stamp", ts - ts0, tcs);
    front <= 1'b1;
    wr(16'h8100, 32'h0);
    wacq(1'b0);
    repeat (40) @(posedge clk);
    check("acq_mode0_input", acq, 1'b0);
    front <= 1'b0;
    $display("test software run done");
    wr(16'h8100, 32'h1);
    repeat (5) @(posedge clk);
    front <= 1'b1;
    wacq(1'b1);
    front <= 1'b0;
    wacq(1'b0);
    wr(16'h8100, 32'h5);
    wacq(1'b1);
    $display("test input run done");
    busy_req <= 1'b1;
    repeat (4) @(posedge clk);
    check("acq_chain_busy", acq, 1'b0);
    check("chain_busy_o", cb_o, 1'b1);
    rdc(16'h8120, 32'h3);
    busy_req <= 1'b0;
    wacq(1'b1);
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    check("acq_local_busy", acq, 1'b0);
    busy <= 1'b0;
    wr(16'h8100, 32'h0);
    wacq(1'b0);
    for (int m = 2; m < 4; m++) begin
      wr(16'h8100, 32'h4 | m);
      repeat (60) @(posedge clk);
      check("acq_reserved_mode", acq, 1'b0);
    end
    wr(16'h8100, 32'h0);
    $display("test busy and modes done");
    wr(16'h8118, 32'h1);
    repeat (60) @(posedge clk);
    check("fwd_staged", fwd, 1'b0);
    wr(16'h811C, 32'h1);
    n = 0;
    p = fwd;
    repeat (100) begin
      @(posedge clk);
      if (fwd !== p) n++;
      p = fwd;
    end
    check("fwd_runs", n > 0, 1'b1);
    rdc(16'h8120, 32'h10);
    sw <= 1'b1;
    repeat (40) @(posedge clk);
    rises(160, cs);
    check("ext_ref_rate", cs, 10);
    rdc(16'h8120, 32'h14);
    sw <= 1'b0;
    slow <= 1'b1;
    wr(16'h8124, 32'h3);
    wr(16'h8118, 32'h3);
    wr(16'h811C, 32'h1);
    rdc(16'h8124, 32'h3);
    rdc(16'h8120, 32'h18);
    repeat (40) @(posedge clk);
    rises(160, cs);
    check("follow_rate", cs, 5);
    $display("test forwarded clock done");
    conclude();
  end
endmodule : tb_digitizer_clocking_and_run_control
`default_nettype wire
